//--- inc/timer_dma_regs.svh
`ifndef TIMER_DMA_REGS_SVH
`define TIMER_DMA_REGS_SVH

// Register indices; byte address is four times the index
`define CPTR_IDX          8'hf0
`define APTR_IDX          8'hf1
`define VEC_IDX           8'hf2
`define CTRL_IDX          8'hf3
`define MASK_IDX          8'hf4
`define LOOP_IDX          8'hf8
`define IDX_W             8
`define IDX_SHIFT         2

// Reset values
`define CPTR_RST          8'h00
`define APTR_RST          8'h00
`define VEC_RST           8'h00
`define CTRL_RST          8'hc7
`define MASK_RST          8'h00
`define LOOP_RST          8'hfc

// Pointer register fields
`define PTR_MSB_HI        7
`define PTR_MSB_LO        2
`define PTR_ORIGIN_BIT    1
`define PTR_SEL_BIT       0
`define PTR_TOGGLE_BIT    0

// Vector register fields
`define VEC_BASE_HI       7
`define VEC_BASE_LO       3
`define VEC_GRP_HI        2
`define VEC_GRP_LO        1

// Control register fields
`define CTRL_CAP_EOB      7
`define CTRL_CMP_EOB      6
`define CTRL_CAP_ORIGIN   5
`define CTRL_CMP_TARGET   4
`define CTRL_SWAP         3
`define CTRL_PRIO_HI      2
`define CTRL_PRIO_LO      0

// Mask register fields
`define MASK_CAP          1
`define MASK_CMP          0

// Loopback register fields
`define LOOP_ODD          1
`define LOOP_EVEN         0

// Vector groups
`define GRP_OVF           2'b00
`define GRP_CAPTURE       2'b10
`define GRP_COMPARE       2'b11

`endif

//--- inc/timer_dma_pkg.sv
`default_nettype none
package timer_dma_pkg;
    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK  = 2'b10
    } apb_state_e;
    typedef logic [7:0] reg8_t;
    typedef logic [2:0] prio_t;
endpackage
`default_nettype wire

//--- logic/timer_dma_interrupt_control.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_dma_regs.svh"

module timer_dma_interrupt_control #(
    parameter int ADDR_W      = 12,
    parameter int TIMER_COUNT = 4
) (
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_reset,
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [ADDR_W-1:0]         i_paddr,
    input  wire logic [31:0]               i_pwdata,
    input  wire logic [3:0]                i_pstrb,
    output var  logic [31:0]               o_prdata,
    output var  logic                      o_pready,
    output var  logic                      o_pslverr,
    input  wire logic                      i_capture_xfer_done,
    input  wire logic                      i_compare_xfer_done,
    input  wire logic                      i_capture_eob,
    input  wire logic                      i_compare_eob,
    input  wire logic                      i_irq_valid,
    input  wire logic [1:0]                i_irq_group,
    input  wire logic [TIMER_COUNT-1:0]    i_timer_output_a,
    input  wire logic [TIMER_COUNT-1:0]    i_timer_input_a_pin,
    output var  logic [TIMER_COUNT-1:0]    o_timer_input_a,
    output var  timer_dma_pkg::reg8_t      o_counter_ptr,
    output var  timer_dma_pkg::reg8_t      o_addr_ptr,
    output var  timer_dma_pkg::reg8_t      o_vector_addr,
    output var  logic                      o_capture_xfer_origin,
    output var  logic                      o_compare_xfer_target,
    output var  logic                      o_swap_enable,
    output var  timer_dma_pkg::prio_t      o_priority_level,
    output var  logic                      o_capture_dma_mask,
    output var  logic                      o_compare_dma_mask,
    output var  logic                      o_dma_to_regfile,
    output var  logic                      o_dma_segment_ext
);
    import timer_dma_pkg::*;

    // Parameter sanity at elaboration: address must hold all indices, timers come in pairs
    if (ADDR_W < `IDX_W + `IDX_SHIFT || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end
    if (TIMER_COUNT < 2 || (TIMER_COUNT % 2) != 0) begin : g_bad_timer_count
        $error("TIMER_COUNT must be even and at least 2");
    end

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] addr_of(input logic [`IDX_W-1:0] idx);
        addr_of = ADDR_W'({idx, 2'b00});
    endfunction

    // Register state
    apb_state_e                 state_reg;        // Bus slave phase
    logic [5:0]                 cptr_msbs_reg;    // Counter pointer high bits
    logic                       cptr_area_reg;    // Register file when set
    logic [5:0]                 aptr_msbs_reg;    // Address pointer high bits
    logic                       seg_sel_reg;      // DMA segment when set
    logic                       origin_reg;       // Shared origin flag
    logic [4:0]                 vec_base_reg;     // Vector base bits
    logic [1:0]                 vec_group_reg;    // Requesting group
    logic                       cap_eob_reg;      // Capture end of block
    logic                       cmp_eob_reg;      // Compare end of block
    logic                       cap_origin_reg;   // Capture from port
    logic                       cmp_target_reg;   // Compare to port
    logic                       swap_reg;         // Swap mode
    prio_t                      prio_reg;         // Priority level
    logic                       cap_mask_reg;     // Capture DMA enable
    logic                       cmp_mask_reg;     // Compare DMA enable
    logic                       odd_sel_reg;      // Odd timer loopback
    logic                       even_sel_reg;     // Even timer loopback
    reg8_t                      rdata_next;       // Read mux result
    logic                       hit_next;         // Address is mapped

    // Write strobe in the access phase, low byte lane only
    logic                       wr_en;
    logic [7:0]                 wd;
    assign wr_en = i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0];
    assign wd    = i_pwdata[7:0];

    // Register-level writes per address
    logic                       wr_cptr;
    logic                       wr_aptr;
    logic                       wr_vec;
    logic                       wr_ctrl;
    logic                       wr_mask;
    logic                       wr_loop;
    assign wr_cptr = wr_en && (i_paddr == addr_of(`CPTR_IDX));
    assign wr_aptr = wr_en && (i_paddr == addr_of(`APTR_IDX));
    assign wr_vec  = wr_en && (i_paddr == addr_of(`VEC_IDX));
    assign wr_ctrl = wr_en && (i_paddr == addr_of(`CTRL_IDX));
    assign wr_mask = wr_en && (i_paddr == addr_of(`MASK_IDX));
    assign wr_loop = wr_en && (i_paddr == addr_of(`LOOP_IDX));

    // Swap-mode compare end of block flips both table selectors
    logic                       swap_flip;
    assign swap_flip = i_compare_eob && swap_reg;

    // Read mux; unused loopback bits read as ones
    always_comb begin
        rdata_next = 8'h00;
        hit_next   = 1'b1;
        if (i_paddr == addr_of(`CPTR_IDX)) begin
            rdata_next = {cptr_msbs_reg, origin_reg, cptr_area_reg};
        end else if (i_paddr == addr_of(`APTR_IDX)) begin
            rdata_next = {aptr_msbs_reg, origin_reg, seg_sel_reg};
        end else if (i_paddr == addr_of(`VEC_IDX)) begin
            rdata_next = {vec_base_reg, vec_group_reg, 1'b0};
        end else if (i_paddr == addr_of(`CTRL_IDX)) begin
            rdata_next = {cap_eob_reg, cmp_eob_reg, cap_origin_reg, cmp_target_reg,
                          swap_reg, prio_reg};
        end else if (i_paddr == addr_of(`MASK_IDX)) begin
            rdata_next = {6'h00, cap_mask_reg, cmp_mask_reg};
        end else if (i_paddr == addr_of(`LOOP_IDX)) begin
            rdata_next = {6'h3f, odd_sel_reg, even_sel_reg};
        end else begin
            // Unmapped: zero data and an error answer
            hit_next = 1'b0;
        end
    end

    // Bus slave: answer in the first access cycle, data from flops
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    // Setup cycle: latch answer for the access cycle
                    if (i_psel && !i_penable) begin
                        state_reg <= ST_ACK;
                        o_pready  <= 1'b1;
                        o_pslverr <= !hit_next;
                        o_prdata  <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rdata_next};
                    end
                end
                ST_ACK: begin
                    // Access cycle completes here
                    state_reg <= ST_IDLE;
                    o_pready  <= 1'b0;
                    o_pslverr <= 1'b0;
                end
            endcase
        end
    end

    // Counter pointer: software high bits and area, hardware bit 2 toggle
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            cptr_msbs_reg <= 6'(`CPTR_RST >> `PTR_MSB_LO);
            cptr_area_reg <= 1'(`CPTR_RST >> `PTR_SEL_BIT);
        end else begin
            if (wr_cptr) begin
                cptr_msbs_reg <= wd[`PTR_MSB_HI:`PTR_MSB_LO];
                cptr_area_reg <= wd[`PTR_SEL_BIT];
            end
            if (swap_flip) begin
                // Hardware toggle inverts the bit written by a same-cycle software write
                cptr_msbs_reg[`PTR_TOGGLE_BIT] <= !(wr_cptr ? wd[`PTR_MSB_LO]
                                                             : cptr_msbs_reg[`PTR_TOGGLE_BIT]);
            end
        end
    end

    // Address pointer: software high bits and segment, hardware bit 2 toggle
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            aptr_msbs_reg <= 6'(`APTR_RST >> `PTR_MSB_LO);
            seg_sel_reg   <= 1'(`APTR_RST >> `PTR_SEL_BIT);
        end else begin
            if (wr_aptr) begin
                aptr_msbs_reg <= wd[`PTR_MSB_HI:`PTR_MSB_LO];
                seg_sel_reg   <= wd[`PTR_SEL_BIT];
            end
            if (swap_flip) begin
                // Table select kept even in register-file mode
                aptr_msbs_reg[`PTR_TOGGLE_BIT] <= !(wr_aptr ? wd[`PTR_MSB_LO]
                                                             : aptr_msbs_reg[`PTR_TOGGLE_BIT]);
            end
        end
    end

    // Origin flag follows the channel whose transfer just finished
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            origin_reg <= 1'b0;
        end else if (i_compare_xfer_done) begin
            origin_reg <= 1'b1;
        end else if (i_capture_xfer_done) begin
            origin_reg <= 1'b0;
        end
    end

    // Vector register: base from software, group from requests
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            vec_base_reg  <= 5'(`VEC_RST >> `VEC_BASE_LO);
            vec_group_reg <= `GRP_OVF;
        end else begin
            if (wr_vec) begin
                vec_base_reg <= wd[`VEC_BASE_HI:`VEC_BASE_LO];
            end
            if (i_irq_valid) begin
                vec_group_reg <= i_irq_group;
            end
        end
    end

    // Control register software fields
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            cap_origin_reg <= 1'(`CTRL_RST >> `CTRL_CAP_ORIGIN);
            cmp_target_reg <= 1'(`CTRL_RST >> `CTRL_CMP_TARGET);
            swap_reg       <= 1'(`CTRL_RST >> `CTRL_SWAP);
            prio_reg       <= 3'(`CTRL_RST >> `CTRL_PRIO_LO);
        end else if (wr_ctrl) begin
            cap_origin_reg <= wd[`CTRL_CAP_ORIGIN];
            cmp_target_reg <= wd[`CTRL_CMP_TARGET];
            swap_reg       <= wd[`CTRL_SWAP];
            prio_reg       <= wd[`CTRL_PRIO_HI:`CTRL_PRIO_LO];
        end
    end

    // End-of-block flags: forced high without swap, event beats clear
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            cap_eob_reg <= 1'(`CTRL_RST >> `CTRL_CAP_EOB);
            cmp_eob_reg <= 1'(`CTRL_RST >> `CTRL_CMP_EOB);
        end else begin
            if (!swap_reg) begin
                cap_eob_reg <= 1'b1;
            end else if (i_capture_eob) begin
                cap_eob_reg <= 1'b1;
            end else if (wr_ctrl) begin
                cap_eob_reg <= wd[`CTRL_CAP_EOB];
            end
            if (!swap_reg) begin
                cmp_eob_reg <= 1'b1;
            end else if (i_compare_eob) begin
                cmp_eob_reg <= 1'b1;
            end else if (wr_ctrl) begin
                cmp_eob_reg <= wd[`CTRL_CMP_EOB];
            end
        end
    end

    // DMA masks: software enables, end of block disables
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            cap_mask_reg <= 1'(`MASK_RST >> `MASK_CAP);
            cmp_mask_reg <= 1'(`MASK_RST >> `MASK_CMP);
        end else begin
            if (wr_mask) begin
                cap_mask_reg <= wd[`MASK_CAP];
            end else if (i_capture_eob) begin
                cap_mask_reg <= 1'b0;
            end
            if (wr_mask) begin
                cmp_mask_reg <= wd[`MASK_CMP];
            end else if (i_compare_eob) begin
                cmp_mask_reg <= 1'b0;
            end
        end
    end

    // Loopback selects
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            odd_sel_reg  <= 1'(`LOOP_RST >> `LOOP_ODD);
            even_sel_reg <= 1'(`LOOP_RST >> `LOOP_EVEN);
        end else if (wr_loop) begin
            odd_sel_reg  <= wd[`LOOP_ODD];
            even_sel_reg <= wd[`LOOP_EVEN];
        end
    end

    // Registered input A per timer: loop from output A or take the pin
    // One process owns the whole vector so no bit has a second writer
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_timer_input_a <= {TIMER_COUNT{1'b0}};
        end else begin
            for (int t = 0; t < TIMER_COUNT; t++) begin
                if ((t % 2) == 1) begin
                    o_timer_input_a[t] <= odd_sel_reg ? i_timer_output_a[t]
                                                      : i_timer_input_a_pin[t];
                end else begin
                    o_timer_input_a[t] <= even_sel_reg ? i_timer_output_a[t]
                                                       : i_timer_input_a_pin[t];
                end
            end
        end
    end

    // Outputs straight from the register flops
    assign o_counter_ptr         = {cptr_msbs_reg, origin_reg, cptr_area_reg};
    assign o_addr_ptr            = {aptr_msbs_reg, origin_reg, seg_sel_reg};
    assign o_vector_addr         = {vec_base_reg, vec_group_reg, 1'b0};
    assign o_capture_xfer_origin = cap_origin_reg;
    assign o_compare_xfer_target = cmp_target_reg;
    assign o_swap_enable         = swap_reg;
    assign o_priority_level      = prio_reg;
    assign o_capture_dma_mask    = cap_mask_reg;
    assign o_compare_dma_mask    = cmp_mask_reg;
    assign o_dma_to_regfile      = cptr_area_reg;
    assign o_dma_segment_ext     = seg_sel_reg;

    // Checks
    AST_CPTR_TOGGLE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (swap_flip && !wr_cptr) |=> (o_counter_ptr[`PTR_MSB_LO] != $past(o_counter_ptr[`PTR_MSB_LO])))
        else $error("counter pointer bit 2 did not toggle");
    AST_APTR_TOGGLE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (swap_flip && !wr_aptr) |=> (o_addr_ptr[`PTR_MSB_LO] != $past(o_addr_ptr[`PTR_MSB_LO])))
        else $error("address pointer bit 2 did not toggle");
    AST_NO_TOGGLE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (!swap_flip && !wr_aptr && !wr_cptr) |=> $stable(o_addr_ptr[`PTR_MSB_HI:`PTR_MSB_LO])
        && $stable(o_counter_ptr[`PTR_MSB_HI:`PTR_MSB_LO]))
        else $error("pointer changed without cause");
    AST_ORIGIN: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_compare_xfer_done |=> o_counter_ptr[`PTR_ORIGIN_BIT] && o_addr_ptr[`PTR_ORIGIN_BIT])
        else $error("origin flag not set by compare");
    AST_VEC_LSB: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !o_vector_addr[0] && !(o_prdata[0] && $past(i_paddr == addr_of(`VEC_IDX) && i_psel
        && !i_penable && !i_pwrite)))
        else $error("vector bit 0 not zero");
    AST_VEC_GROUP: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_irq_valid |=> o_vector_addr[`VEC_GRP_HI:`VEC_GRP_LO] == $past(i_irq_group))
        else $error("vector group not captured");
    AST_EOB_FORCED: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !o_swap_enable [*2] |-> cap_eob_reg && cmp_eob_reg)
        else $error("end-of-block flag low with swap off");
    AST_EOB_SET: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_compare_eob && o_swap_enable) |=> cmp_eob_reg)
        else $error("compare end-of-block flag not set");
    AST_MASK_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_capture_eob && !wr_mask) |=> !o_capture_dma_mask)
        else $error("capture mask not cleared at end of block");
    AST_LOOP_EVEN: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        ($past(even_sel_reg) && $past(!i_reset)) |-> o_timer_input_a[0] == $past(i_timer_output_a[0]))
        else $error("even loopback not routed");
    AST_READY: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_psel && !i_penable && state_reg == ST_IDLE) |=> o_pready ##1 !o_pready)
        else $error("bus answer not one cycle after setup");

endmodule

`default_nettype wire

//--- testbench/dma_irq_partner.sv
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the on-chip DMA and interrupt controller; fires one event per request
module dma_irq_partner (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset,
    input  wire logic       i_go,        // Start one event
    input  wire logic [2:0] i_kind,      // 0..3 done/eob events, 4 interrupt
    input  wire logic [1:0] i_group,     // Requesting group
    input  wire logic [3:0] i_wait,      // Extra cycles before the pulse
    output var  logic       o_busy,      // Event pending
    output var  logic       o_cap_done,  // Capture transfer done pulse
    output var  logic       o_cmp_done,  // Compare transfer done pulse
    output var  logic       o_cap_eob,   // Capture end of block pulse
    output var  logic       o_cmp_eob,   // Compare end of block pulse
    output var  logic       o_irq_valid, // Interrupt request pulse
    output var  logic [1:0] o_irq_group  // Group, scrambled when idle
);
    logic [2:0] kind_reg; // Latched request
    logic [3:0] cnt_reg;  // Delay count
    logic [1:0] grp_reg;  // Latched group

    // Pulses last one cycle; group lines change every idle cycle
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            {o_busy, o_cap_done, o_cmp_done, o_cap_eob, o_cmp_eob, o_irq_valid} <= '0;
            o_irq_group <= 2'b11;
        end else begin
            {o_cap_done, o_cmp_done, o_cap_eob, o_cmp_eob, o_irq_valid} <= '0;
            o_irq_group <= ~o_irq_group;
            if (i_go) begin
                kind_reg <= i_kind;
                grp_reg  <= i_group;
                cnt_reg  <= i_wait;
                o_busy   <= 1'b1;
            end else if (o_busy && cnt_reg != 4'h0) begin
                cnt_reg <= cnt_reg - 4'h1;
            end else if (o_busy) begin
                o_busy <= 1'b0;
                case (kind_reg)
                    3'd0: o_cap_done <= 1'b1;
                    3'd1: o_cmp_done <= 1'b1;
                    3'd2: o_cap_eob <= 1'b1;
                    3'd3: o_cmp_eob <= 1'b1;
                    default: begin
                        // Group tells the handler which flags to read next
                        o_irq_valid <= 1'b1;
                        o_irq_group <= grp_reg;
                    end
                endcase
            end
        end
    end
endmodule

`default_nettype wire

//--- testbench/test_timer_dma_interrupt_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_dma_regs.svh"

module test_timer_dma_interrupt_control;
    import timer_dma_pkg::*;
    logic        clk_sys = 1'b0, reset = 1'b1;           // Clock and reset
    logic        psel, penable, pwrite, pready, pslverr; // Bus controls
    logic [11:0] paddr;                                  // Byte address
    logic [31:0] pwdata, prdata, rd_data;                // Bus data
    logic [3:0]  pstrb, out_a, pin_a, in_a, dly;         // Strobes, timer lines
    logic        rd_err, go, busy, cap_done, cmp_done, cap_eob, cmp_eob, irq_v;
    logic [2:0]  kind;                                   // Event kind
    logic [1:0]  grp, irq_g;                             // Interrupt group
    reg8_t       cptr, aptr, vaddr;                      // Pointer outputs
    prio_t       prio;                                   // Priority output
    logic        cap_org, cmp_tgt, swap, cap_mask, cmp_mask, to_rf, seg_ext;
    int          n_fail = 0, n_tests = 0;                // Counters
    logic [7:0]  idx_tab [6] = '{8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf8};
    logic [7:0]  rst_tab [6] = '{8'h00, 8'h00, 8'h00, 8'hc7, 8'h00, 8'hfc};
    logic [1:0]  g_tab [3]   = '{2'b10, 2'b11, 2'b00};

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    timer_dma_interrupt_control dut (.i_clk_sys(clk_sys), .i_reset(reset), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_capture_xfer_done(cap_done), .i_compare_xfer_done(cmp_done),
        .i_capture_eob(cap_eob), .i_compare_eob(cmp_eob), .i_irq_valid(irq_v),
        .i_irq_group(irq_g), .i_timer_output_a(out_a), .i_timer_input_a_pin(pin_a),
        .o_timer_input_a(in_a), .o_counter_ptr(cptr), .o_addr_ptr(aptr),
        .o_vector_addr(vaddr), .o_capture_xfer_origin(cap_org),
        .o_compare_xfer_target(cmp_tgt), .o_swap_enable(swap), .o_priority_level(prio),
        .o_capture_dma_mask(cap_mask), .o_compare_dma_mask(cmp_mask),
        .o_dma_to_regfile(to_rf), .o_dma_segment_ext(seg_ext));

    dma_irq_partner far (.i_clk_sys(clk_sys), .i_reset(reset), .i_go(go), .i_kind(kind),
        .i_group(grp), .i_wait(dly), .o_busy(busy), .o_cap_done(cap_done),
        .o_cmp_done(cmp_done), .o_cap_eob(cap_eob), .o_cmp_eob(cmp_eob),
        .o_irq_valid(irq_v), .o_irq_group(irq_g));

    // Verdict and end of run
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One bus transfer; request held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] data);
        int i;
        @(posedge clk_sys);
        {psel, penable, pwrite} <= {1'b1, 1'b0, wr};
        paddr  <= {2'b00, idx, 2'b00};
        pwdata <= data;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            chk(0, 1, "no ready");
            report_and_stop();
        end
        rd_data = prdata;
        rd_err  = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    // Write, then let registered outputs settle
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h0, d});
        repeat (2) @(posedge clk_sys);
    endtask

    // Read and compare data and error
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
        apb(1'b0, idx, 32'h0);
        chk(rd_data, {24'h0, exp}, what);
        chk({31'h0, rd_err}, 32'h0, "error flag");
    endtask

    // Have the partner fire one event, then wait for it to land
    task automatic ev(input logic [2:0] k, input logic [1:0] g, input logic [3:0] w);
        int i;
        @(posedge clk_sys);
        {go, kind, grp, dly} <= {1'b1, k, g, w};
        @(posedge clk_sys);
        go <= 1'b0;
        for (i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            if (busy === 1'b0) break;
        end
        if (i == 40) begin
            chk(0, 1, "partner hung");
            report_and_stop();
        end
        @(posedge clk_sys);
    endtask

    // Main sequence
    initial begin
        {psel, penable, pwrite, go, kind, grp, dly} = '0;
        {paddr, pwdata, pstrb, out_a, pin_a} = {12'h0, 32'h0, 4'hf, 4'h3, 4'hc};
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        foreach (idx_tab[i]) rd(idx_tab[i], rst_tab[i], "reset value");
        chk(in_a, 4'hc, "loopback off");
        apb(1'b0, 8'hf5, 32'h0);
        chk({31'h0, rd_err}, 32'h1, "unmapped error");
        wr(`CPTR_IDX, 8'hff);
        rd(`CPTR_IDX, 8'hfd, "counter pointer");
        chk(to_rf, 1, "register file area");
        wr(`APTR_IDX, 8'hff);
        rd(`APTR_IDX, 8'hfd, "address pointer");
        chk(seg_ext, 1, "segment select");
        ev(3'd1, 2'b00, 4'd5);
        chk({aptr, cptr}, 16'hffff, "compare origin");
        ev(3'd0, 2'b00, 4'd0);
        chk({aptr, cptr}, 16'hfdfd, "capture origin");
        wr(`VEC_IDX, 8'hff);
        rd(`VEC_IDX, 8'hf8, "vector base");
        foreach (g_tab[j]) begin
            ev(3'd4, g_tab[j], 4'd2);
            rd(`VEC_IDX, {5'h1f, g_tab[j], 1'b0}, "vector group");
            chk(vaddr, {5'h1f, g_tab[j], 1'b0}, "vector output");
        end
        for (int p = 0; p < 8; p++) begin
            wr(`CTRL_IDX, 8'(p));
            chk(prio, p, "priority");
        end
        wr(`CTRL_IDX, 8'h0d);
        rd(`CTRL_IDX, 8'hcd, "swap on, flags still held");
        wr(`CTRL_IDX, 8'h0d);
        rd(`CTRL_IDX, 8'h0d, "swap on, flags cleared");
        ev(3'd3, 2'b00, 4'd0);
        rd(`CTRL_IDX, 8'h4d, "compare end of block");
        chk({aptr, cptr}, 16'hf9f9, "table swap");
        ev(3'd2, 2'b00, 4'd3);
        rd(`CTRL_IDX, 8'hcd, "capture end of block");
        chk(cptr, 8'hf9, "capture does not swap");
        wr(`CTRL_IDX, 8'h30);
        rd(`CTRL_IDX, 8'hf0, "flags forced");
        chk({cap_org, cmp_tgt, swap}, 3'b110, "port selects");
        wr(`MASK_IDX, 8'h03);
        chk({cap_mask, cmp_mask}, 2'b11, "masks set");
        ev(3'd3, 2'b00, 4'd0);
        chk({cap_mask, cmp_mask, cptr}, {2'b10, 8'hf9}, "compare mask cleared");
        ev(3'd2, 2'b00, 4'd0);
        rd(`MASK_IDX, 8'h00, "capture mask cleared");
        pstrb <= 4'he;
        wr(`CTRL_IDX, 8'h08);
        pstrb <= 4'hf;
        rd(`CTRL_IDX, 8'hf0, "strobe off ignored");
        wr(`LOOP_IDX, 8'h01);
        chk(in_a, 4'h9, "even loopback");
        rd(`LOOP_IDX, 8'hfd, "loopback reg");
        wr(`LOOP_IDX, 8'h02);
        chk(in_a, 4'h6, "odd loopback");
        report_and_stop();
    end
endmodule

`default_nettype wire
